/* sbcl_top.v */
// Command decode and bank legality for the whole device.
`timescale 1ns/1ns
`default_nettype none
`include "sbcl_map.vh"
module sbcl_top #(
    parameter [7:0] SR_EXIT_CYC = `SBCL_SR_EXIT_CYC
) (
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    input wire cke,
    input wire sr_exit,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [1:0] bank_addr,
    input wire auto_pre,
    output reg [31:0] bank_state,
    output reg all_idle,
    output reg cmd_illegal,
    output reg [3:0] last_cmd,
    output reg [1:0] burst_bank,
    output reg burst_on,
    output reg dbus_take,
    output reg [1:0] dbus_bank,
    output reg wr_end
);
    localparam [7:0] REF_CYC = `SBCL_REFRESH_CYC;
    localparam [7:0] MRS_CYC = `SBCL_MODE_LOAD_CYC;
    localparam [7:0] PRE_CYC = `SBCL_PRECHARGE_CYC;
    localparam [7:0] BL = `SBCL_BURST_LEN;
    localparam [3:0] G_NONE = 4'h1;
    localparam [3:0] G_REF = 4'h2;
    localparam [3:0] G_MRS = 4'h4;
    localparam [3:0] G_PALL = 4'h8;
    localparam [2:0] CL = `SBCL_CAS_LATENCY;
    reg [1:0] cke_s1;
    reg [1:0] cke_s2;
    reg [3:0] pin_s1;
    reg [3:0] pin_s2;
    reg [2:0] ba_s1;
    reg [2:0] ba_s2;
    reg cke_prev;
    reg sr_prev;
    reg [7:0] xsr_cnt;
    reg [3:0] gstate;
    reg [7:0] gcnt;
    reg [7:0] bcnt;
    reg [2:0] cl_pipe;
    reg [1:0] cl_bank0;
    reg [1:0] cl_bank1;
    reg [3:0] next_gstate;
    reg [7:0] next_gcnt;
    reg [1:0] next_burst_bank;
    reg next_burst_on;
    reg [7:0] next_bcnt;
    reg next_illegal;
    wire [3:0] cmd;
    wire [1:0] ba;
    wire apf;
    wire go;
    wire glob_free;
    wire [3:0] bank_sel;
    wire [3:0] bank_ill;
    wire [3:0] bank_idle;
    wire [3:0] bank_rd;
    wire [3:0] bank_wr;
    wire is_rd;
    wire is_wr;
    wire is_pall;
    wire is_bst;
    wire [31:0] st_w;
    // Strobes pass two flip-flops, then are read together as one command.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cke_s1 <= 2'h0;
            cke_s2 <= 2'h0;
            pin_s1 <= 4'hf;
            pin_s2 <= 4'hf;
            ba_s1 <= 3'h0;
            ba_s2 <= 3'h0;
        end else if (clk_en) begin
            cke_s1 <= {sr_exit, cke};
            cke_s2 <= cke_s1;
            pin_s1 <= {cs_n, ras_n, cas_n, we_n}; // [R26]
            pin_s2 <= pin_s1;
            ba_s1 <= {auto_pre, bank_addr};
            ba_s2 <= ba_s1;
        end
    end
    assign cmd = pin_s2[3] ? `SBCL_CMD_INHIBIT : {1'b0, pin_s2[2:0]}; // [R1] [R2] [R26]
    assign ba = ba_s2[1:0];
    assign apf = ba_s2[2];
    // Self-refresh exit holds decoding off for the exit time.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cke_prev <= 1'b0;
            sr_prev <= 1'b0;
            xsr_cnt <= 8'h00;
        end else if (clk_en) begin
            cke_prev <= cke_s2[0];
            sr_prev <= cke_s2[1];
            if (cke_s2[1] && !sr_prev) begin
                xsr_cnt <= SR_EXIT_CYC;
            end else if (xsr_cnt != 8'h00) begin
                xsr_cnt <= xsr_cnt - 8'h01;
            end
        end
    end
    assign go = clk_en && cke_prev && cke_s2[0] && (xsr_cnt == 8'h00) && glob_free; // [R11]
    assign glob_free = (gstate == G_NONE);
    assign is_rd = (cmd == `SBCL_CMD_READ);
    assign is_wr = (cmd == `SBCL_CMD_WRITE);
    assign is_bst = (cmd == `SBCL_CMD_BST);
    assign is_pall = (cmd == `SBCL_CMD_PRE) && apf; // [R7]
    genvar gi;
    generate
        for (gi = 0; gi < `SBCL_BANKS; gi = gi + 1) begin : g_bank
            assign bank_sel[gi] = (ba == gi);
            assign bank_idle[gi] = st_w[gi*8 +: 8] == `SBCL_ST_IDLE;
            assign bank_rd[gi] = st_w[gi*8 +: 8] == `SBCL_ST_READ;
            assign bank_wr[gi] = st_w[gi*8 +: 8] == `SBCL_ST_WRITE;
            sbcl_bank u_bank (
                .sys_clk(sys_clk),
                .rst(rst),
                .ce(clk_en),
                .go(go),
                .sel(bank_sel[gi]),
                .cmd(cmd),
                .ap(apf),
                .pre_all(is_pall),
                .stop_burst(is_bst && burst_on && burst_bank == gi), // [R10]
                .burst_done(burst_on && burst_bank == gi && bcnt == 8'h01),
                .other_access((is_rd || is_wr) && !bank_sel[gi]), // [R21] [R22]
                .state(st_w[gi*8 +: 8]),
                .illegal(bank_ill[gi])
            );
        end
    endgenerate
    // Global states: refresh, mode load and precharge-all.
    always @* begin
        next_gstate = gstate;
        next_gcnt = (gcnt != 8'h00) ? gcnt - 8'h01 : 8'h00;
        next_illegal = 1'b0;
        case (gstate)
            G_NONE: begin
                if (go && cmd == `SBCL_CMD_REF) begin
                    next_illegal = (bank_idle != 4'hf); // [R4]
                    next_gstate = G_REF; // [R16]
                    next_gcnt = REF_CYC - 8'h01;
                end else if (go && cmd == `SBCL_CMD_MRS) begin
                    next_illegal = (bank_idle != 4'hf); // [R4]
                    next_gstate = G_MRS; // [R17]
                    next_gcnt = MRS_CYC - 8'h01;
                end else if (go && is_pall) begin
                    next_gstate = G_PALL; // [R18]
                    next_gcnt = PRE_CYC - 8'h01;
                end
            end
            G_REF, G_MRS, G_PALL: begin
                if (cmd != `SBCL_CMD_INHIBIT && cmd != `SBCL_CMD_NOP && clk_en) begin
                    next_illegal = 1'b1; // [R16] [R17] [R18]
                end
                if (gcnt == 8'h00) begin
                    next_gstate = G_NONE;
                end
            end
            default: begin
                next_gstate = G_NONE;
            end
        endcase
    end
    // Most recent burst, for terminate and for the end-of-burst return to row active.
    always @* begin
        next_burst_bank = burst_bank;
        next_burst_on = burst_on;
        next_bcnt = (bcnt != 8'h00) ? bcnt - 8'h01 : 8'h00;
        if (go && (is_rd || is_wr)) begin
            next_burst_bank = ba;
            next_burst_on = 1'b1;
            next_bcnt = BL;
        end else if (go && (is_bst || (cmd == `SBCL_CMD_PRE && (is_pall || ba == burst_bank)))) begin
            next_burst_on = 1'b0; // [R10] [R8] [R9]
            next_bcnt = 8'h00;
        end else if (bcnt == 8'h01) begin
            next_burst_on = 1'b0;
        end
    end
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gstate <= G_NONE;
            gcnt <= 8'h00;
            burst_bank <= 2'h0;
            burst_on <= 1'b0;
            bcnt <= 8'h00;
            cl_pipe <= 3'h0;
            cl_bank0 <= 2'h0;
            cl_bank1 <= 2'h0;
            bank_state <= 32'h01010101;
            all_idle <= 1'b1;
            cmd_illegal <= 1'b0;
            last_cmd <= `SBCL_CMD_INHIBIT;
            dbus_take <= 1'b0;
            dbus_bank <= 2'h0;
            wr_end <= 1'b0;
        end else if (clk_en) begin
            gstate <= next_gstate;
            gcnt <= next_gcnt;
            burst_bank <= next_burst_bank;
            burst_on <= next_burst_on;
            bcnt <= next_bcnt;
            cl_pipe <= {cl_pipe[1:0], go && is_rd}; // [R23]
            cl_bank0 <= ba;
            cl_bank1 <= cl_bank0;
            dbus_take <= cl_pipe[CL-2]; // [R23]
            dbus_bank <= cl_bank1;
            wr_end <= go && is_rd && (bank_wr != 4'h0); // [R25]
            bank_state <= st_w;
            all_idle <= (bank_idle == 4'hf) && glob_free; // [R19] [R20]
            cmd_illegal <= next_illegal || (bank_ill != 4'h0); // [R13]
            last_cmd <= cmd;
        end
    end
endmodule // sbcl_top
`default_nettype wire

/* sbcl_map.vh */
// Constants for the bank command legality block.
// Function
// R1: Chip select high is a command inhibit; everything continues unchanged.
// R2: Select low with row, column and write strobes high decodes as no-operation.
// R3: Activate opens a row in an idle bank.
// R4: Auto refresh and mode load are accepted only when every bank is idle.
// R5: Precharge to an idle bank leaves it unchanged.
// R6: Read or write to a row-active bank starts a burst, optional auto precharge.
// R7: Precharge closes an active row; precharge-all needs every bank valid.
// R8: Reading bank: new read restarts burst, precharge truncates and precharges.
// R9: Writing bank: write or read starts burst, precharge truncates and precharges.
// R10: Burst terminate stops the most recent burst on whichever bank holds it.
// R11: Decoding acts only with clock gate high twice and self-refresh exit time met.
// R12: Bank idle after precharge time; row active after activate-to-column time.
// R13: Controller sends nothing to a bank busy precharging, activating or auto precharging.
// R14: Activating lasts from activate until activate-to-column time, then row active.
// R15: Auto-precharge access holds bank until precharge time, then idle.
// R16: Refreshing lasts refresh cycle time, then all idle; only inhibit or no-op meanwhile.
// R17: Mode access lasts mode-load time, then all idle; only inhibit or no-op meanwhile.
// R18: Precharge-all lasts precharge time, then all idle; no commands meanwhile.
// R19: An idle bank places no restriction on commands to other banks.
// R20: Activating, active or precharging bank allows commands to other banks.
// R21: Reading bank: read to another bank starts a new burst; others accepted.
// R22: Writing bank: write to another bank starts a new burst; others accepted.
// R23: Interrupting read takes the data bus one CAS latency after registration.
// R24: Controller masks data two clocks before a write interrupting a read.
// R25: Read interrupting a write ends bank n write data one clock before it.
// R26: All strobes are sampled together each edge as one command.
`ifndef SBCL_MAP_VH
`define SBCL_MAP_VH
`define SBCL_CLK_PERIOD_NS 10
`define SBCL_PRECHARGE_TIME_NS 18
`define SBCL_ACT_TO_COL_TIME_NS 18
`define SBCL_REFRESH_CYCLE_TIME_NS 60
`define SBCL_MODE_LOAD_TIME_NS 20
`define SBCL_SR_EXIT_TIME_NS 120
`define SBCL_CYC(t) (((t) + `SBCL_CLK_PERIOD_NS - 1) / `SBCL_CLK_PERIOD_NS)
`define SBCL_PRECHARGE_CYC `SBCL_CYC(`SBCL_PRECHARGE_TIME_NS)
`define SBCL_ACT_TO_COL_CYC `SBCL_CYC(`SBCL_ACT_TO_COL_TIME_NS)
`define SBCL_REFRESH_CYC `SBCL_CYC(`SBCL_REFRESH_CYCLE_TIME_NS)
`define SBCL_MODE_LOAD_CYC `SBCL_CYC(`SBCL_MODE_LOAD_TIME_NS)
`define SBCL_SR_EXIT_CYC `SBCL_CYC(`SBCL_SR_EXIT_TIME_NS)
`define SBCL_CAS_LATENCY 3
`define SBCL_BURST_LEN 4
`define SBCL_BANKS 4
`define SBCL_CMD_INHIBIT 4'h8
`define SBCL_CMD_NOP 4'h7
`define SBCL_CMD_ACTIVE 4'h3
`define SBCL_CMD_READ 4'h5
`define SBCL_CMD_WRITE 4'h4
`define SBCL_CMD_BST 4'h6
`define SBCL_CMD_PRE 4'h2
`define SBCL_CMD_REF 4'h1
`define SBCL_CMD_MRS 4'h0
`define SBCL_ST_IDLE 8'h01
`define SBCL_ST_ACTING 8'h02
`define SBCL_ST_ACTIVE 8'h04
`define SBCL_ST_READ 8'h08
`define SBCL_ST_WRITE 8'h10
`define SBCL_ST_PRE 8'h20
`define SBCL_ST_RDAP 8'h40
`define SBCL_ST_WRAP 8'h80
`endif

/* sbcl_bank.v */
// One bank's state machine.
`timescale 1ns/1ns
`default_nettype none
`include "sbcl_map.vh"
module sbcl_bank (
    input wire sys_clk,
    input wire rst,
    input wire ce,
    input wire go,
    input wire sel,
    input wire [3:0] cmd,
    input wire ap,
    input wire pre_all,
    input wire stop_burst,
    input wire burst_done,
    input wire other_access,
    output reg [7:0] state,
    output reg illegal
);
    localparam [7:0] ST_IDLE = `SBCL_ST_IDLE;
    localparam [7:0] ST_ACTING = `SBCL_ST_ACTING;
    localparam [7:0] ST_ACTIVE = `SBCL_ST_ACTIVE;
    localparam [7:0] ST_READ = `SBCL_ST_READ;
    localparam [7:0] ST_WRITE = `SBCL_ST_WRITE;
    localparam [7:0] ST_PRE = `SBCL_ST_PRE;
    localparam [7:0] ST_RDAP = `SBCL_ST_RDAP;
    localparam [7:0] ST_WRAP = `SBCL_ST_WRAP;
    localparam [7:0] PRE_CYC = `SBCL_PRECHARGE_CYC;
    localparam [7:0] ACT_CYC = `SBCL_ACT_TO_COL_CYC;
    localparam [7:0] AP_CYC = `SBCL_PRECHARGE_CYC + `SBCL_BURST_LEN;
    reg [7:0] cnt;
    reg [7:0] next_state;
    reg [7:0] next_cnt;
    reg next_illegal;
    wire is_pre = (cmd == `SBCL_CMD_PRE) && (sel || pre_all);
    wire is_rd = sel && (cmd == `SBCL_CMD_READ);
    wire is_wr = sel && (cmd == `SBCL_CMD_WRITE);
    wire is_act = sel && (cmd == `SBCL_CMD_ACTIVE);
    wire col = is_rd || is_wr;
    always @* begin
        next_state = state;
        next_cnt = (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
        next_illegal = 1'b0;
        if (go) begin
            case (state)
                ST_IDLE: begin
                    if (is_act) begin // [R3] [R14]
                        next_state = ST_ACTING;
                        next_cnt = ACT_CYC - 8'h01;
                    end else if (col) begin
                        next_illegal = 1'b1;
                    end // [R5] precharge to idle does nothing.
                end
                ST_ACTING: begin
                    if (is_act || col || (is_pre && sel)) begin
                        next_illegal = 1'b1; // [R13]
                    end
                    if (cnt == 8'h00) begin
                        next_state = ST_ACTIVE; // [R14] [R12]
                    end
                end
                ST_ACTIVE, ST_READ, ST_WRITE: begin
                    if (is_pre) begin // [R7] [R8] [R9]
                        next_state = ST_PRE;
                        next_cnt = PRE_CYC - 8'h01;
                    end else if (col) begin // [R6] [R8] [R9]
                        next_state = ap ? (is_rd ? ST_RDAP : ST_WRAP) : (is_rd ? ST_READ : ST_WRITE);
                        next_cnt = AP_CYC - 8'h01;
                    end else if (is_act) begin
                        next_illegal = 1'b1;
                    end else if (state != ST_ACTIVE && (stop_burst || burst_done || other_access)) begin
                        next_state = ST_ACTIVE; // [R10] [R21] [R22] [R25]
                    end
                end
                ST_PRE, ST_RDAP, ST_WRAP: begin
                    if (is_act || col || (is_pre && sel)) begin
                        next_illegal = 1'b1; // [R13]
                    end
                    if (cnt == 8'h00) begin
                        next_state = ST_IDLE; // [R12] [R15]
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            cnt <= 8'h00;
            illegal <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            cnt <= next_cnt;
            illegal <= next_illegal;
        end
    end
endmodule // sbcl_bank
`default_nettype wire

/* sbcl_top_sva.sv */
// Concurrent checks on the ports of the bank legality block.
`timescale 1ns/1ns
`default_nettype none
`include "sbcl_map.vh"
module sbcl_top_sva #(
    parameter [7:0] SR_EXIT_CYC = 8'h0c
) (
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    input wire cke,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [1:0] bank_addr,
    input wire [31:0] bank_state,
    input wire all_idle,
    input wire [3:0] last_cmd,
    input wire dbus_take,
    input wire [1:0] dbus_bank
);
    logic [4:0] quiet;
    wire nop_pin = !cs_n && ras_n && cas_n && we_n && clk_en && cke;
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            quiet <= 5'h00;
        end else if (nop_pin) begin
            quiet <= (quiet == 5'h14) ? quiet : quiet + 5'h01;
        end else begin
            quiet <= 5'h00;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    chk_inhibit_decode: assert property (
        (cs_n && clk_en && cke)[*8] |-> last_cmd == `SBCL_CMD_INHIBIT)
        else $error("Inhibit not decoded.");
    chk_nop_decode: assert property (quiet >= 5'h10 |-> last_cmd == `SBCL_CMD_NOP)
        else $error("No-operation not decoded.");
    chk_idle_leaves_act: assert property ($fell(bank_state[0]) |-> bank_state[1])
        else $error("Idle bank left without activate.");
    chk_act_to_active: assert property (
        $rose(bank_state[1]) |-> ##[2:3] bank_state[2])
        else $error("Activating did not end in row active.");
    chk_pre_to_idle: assert property ($rose(bank_state[5]) |-> ##[2:3] bank_state[0])
        else $error("Precharging did not end in idle.");
    chk_autopre_idle: assert property (
        $rose(bank_state[6]) |-> ##[2:10] bank_state[0])
        else $error("Auto precharge did not end in idle.");
    chk_all_idle_flag: assert property (
        all_idle |-> bank_state == 32'h01010101)
        else $error("All-idle flag disagrees with bank states.");
    chk_read_dbus: assert property (
        (!cs_n && ras_n && !cas_n && we_n && bank_addr == 2'h0 && bank_state[2] && clk_en
        && cke) |-> ##[2:7] (dbus_take && dbus_bank == 2'h0))
        else $error("Read did not take the data bus.");
    cov_read: cover property ($rose(bank_state[3]));
    cov_autopre: cover property ($rose(bank_state[6]));
    cov_busy: cover property ($fell(all_idle));
endmodule // sbcl_top_sva
bind sbcl_top sbcl_top_sva #(.SR_EXIT_CYC(SR_EXIT_CYC)) u_sva (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .cke(cke),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .bank_addr(bank_addr),
    .bank_state(bank_state),
    .all_idle(all_idle),
    .last_cmd(last_cmd),
    .dbus_take(dbus_take),
    .dbus_bank(dbus_bank)
);
`default_nettype wire

/* sbcl_ctl_model.sv */
// Memory controller model that turns command requests into strobes.
`timescale 1ns/1ns
`default_nettype none
`include "sbcl_map.vh"
module sbcl_ctl_model (
    input wire logic sys_clk,
    input wire logic [3:0] req_cmd,
    input wire logic [1:0] req_bank,
    input wire logic req_ap,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] bank_addr,
    output logic auto_pre
);
    logic [3:0] s;
    initial begin
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        bank_addr = 2'h0;
        auto_pre = 1'b0;
    end
    always @(posedge sys_clk) begin
        #1;
        case (req_cmd)
            `SBCL_CMD_INHIBIT: s = 4'hf;
            `SBCL_CMD_ACTIVE: s = 4'h3;
            `SBCL_CMD_READ: s = 4'h5;
            `SBCL_CMD_WRITE: s = 4'h4;
            `SBCL_CMD_BST: s = 4'h6;
            `SBCL_CMD_PRE: s = 4'h2;
            `SBCL_CMD_REF: s = 4'h1;
            `SBCL_CMD_MRS: s = 4'h0;
            default: s = 4'h7;
        endcase
        {cs_n, ras_n, cas_n, we_n} = s;
        bank_addr = (s[3] || s == 4'h7) ? ~bank_addr : req_bank;
        auto_pre = (s[3] || s == 4'h7) ? ~auto_pre : req_ap;
    end
endmodule // sbcl_ctl_model
`default_nettype wire

/* test_sdram_bank_command_legality.sv */
// Self-checking bench for the bank legality block.
`timescale 1ns/1ns
`default_nettype none
`include "sbcl_map.vh"
module test_sdram_bank_command_legality;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic cke = 1'b1;
    logic sr_exit = 1'b0;
    logic [3:0] req_cmd = `SBCL_CMD_NOP;
    logic [1:0] req_bank = 2'h0;
    logic req_ap = 1'b0;
    wire cs_n, ras_n, cas_n, we_n, auto_pre, all_idle, cmd_illegal, burst_on, dbus_take, wr_end;
    wire [1:0] bank_addr, burst_bank, dbus_bank;
    wire [31:0] bank_state;
    wire [3:0] last_cmd;
    int n_errors = 0;
    int checks = 0;
    always #5 sys_clk = ~sys_clk;
    sbcl_ctl_model u_ctl (.sys_clk(sys_clk), .req_cmd(req_cmd), .req_bank(req_bank),
        .req_ap(req_ap), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_addr(bank_addr), .auto_pre(auto_pre));
    sbcl_top #(.SR_EXIT_CYC(8'h08)) dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .cke(cke), .sr_exit(sr_exit), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_addr(bank_addr), .auto_pre(auto_pre), .bank_state(bank_state),
        .all_idle(all_idle), .cmd_illegal(cmd_illegal), .last_cmd(last_cmd),
        .burst_bank(burst_bank), .burst_on(burst_on), .dbus_take(dbus_take),
        .dbus_bank(dbus_bank), .wr_end(wr_end));
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(input logic [3:0] c, input logic [1:0] b, input logic ap);
        @(posedge sys_clk);
        req_cmd <= c;
        req_bank <= b;
        req_ap <= ap;
        @(posedge sys_clk);
        req_cmd <= `SBCL_CMD_NOP;
    endtask
    task automatic wait_st(input int b, input logic [7:0] v, input string what);
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            #2;
            if (bank_state[b*8 +: 8] === v) break;
        end
        check(what, v, bank_state[b*8 +: 8]);
        if (i == 20) results();
    endtask
    task automatic wait_flag(input int k, input string what);
        int i;
        for (i = 0; i < 12; i++) begin
            @(posedge sys_clk);
            #2;
            if ((k == 0 ? dbus_take : wr_end) === 1'b1) break;
        end
        check(what, 1'b1, k == 0 ? dbus_take : wr_end);
        if (i == 12) results();
    endtask
    task automatic hold(input logic [3:0] c);
        @(posedge sys_clk);
        req_cmd <= c;
        repeat (10) @(posedge sys_clk);
        #2;
        check("last_cmd", c, last_cmd);
    endtask
    task automatic t_decode();
        check("bank_state", 32'h01010101, bank_state);
        check("all_idle", 1'b1, all_idle);
        hold(`SBCL_CMD_INHIBIT);
        hold(`SBCL_CMD_NOP);
        $display("done decode");
    endtask
    task automatic t_read();
        send(`SBCL_CMD_ACTIVE, 2'h0, 1'b0);
        wait_st(0, `SBCL_ST_ACTING, "bank0");
        wait_st(0, `SBCL_ST_ACTIVE, "bank0");
        send(`SBCL_CMD_ACTIVE, 2'h2, 1'b0);
        send(`SBCL_CMD_READ, 2'h0, 1'b0);
        send(`SBCL_CMD_READ, 2'h0, 1'b0);
        fork
            wait_st(0, `SBCL_ST_READ, "bank0");
            wait_flag(0, "dbus_take");
        join
        check("dbus_bank", 2'h0, dbus_bank);
        send(`SBCL_CMD_PRE, 2'h0, 1'b0);
        wait_st(0, `SBCL_ST_READ, "bank0");
        wait_st(0, `SBCL_ST_PRE, "bank0");
        wait_st(0, `SBCL_ST_IDLE, "bank0");
        check("bank2", `SBCL_ST_ACTIVE, bank_state[23:16]);
        send(`SBCL_CMD_PRE, 2'h2, 1'b0);
        wait_st(2, `SBCL_ST_IDLE, "bank2");
        $display("done read");
    endtask
    task automatic t_write();
        send(`SBCL_CMD_ACTIVE, 2'h0, 1'b0);
        wait_st(0, `SBCL_ST_ACTIVE, "bank0");
        send(`SBCL_CMD_WRITE, 2'h0, 1'b0);
        send(`SBCL_CMD_BST, 2'h0, 1'b0);
        repeat (3) @(posedge sys_clk);
        #2;
        check("bank0", `SBCL_ST_ACTIVE, bank_state[7:0]);
        send(`SBCL_CMD_WRITE, 2'h0, 1'b0);
        send(`SBCL_CMD_READ, 2'h0, 1'b0);
        fork
            wait_flag(1, "wr_end");
            wait_st(0, `SBCL_ST_READ, "bank0");
        join
        send(`SBCL_CMD_PRE, 2'h0, 1'b0);
        wait_st(0, `SBCL_ST_IDLE, "bank0");
        send(`SBCL_CMD_ACTIVE, 2'h0, 1'b0);
        wait_st(0, `SBCL_ST_ACTIVE, "bank0");
        send(`SBCL_CMD_READ, 2'h0, 1'b1);
        wait_st(0, `SBCL_ST_RDAP, "bank0");
        wait_st(0, `SBCL_ST_IDLE, "bank0");
        $display("done write");
    endtask
    task automatic t_global();
        send(`SBCL_CMD_ACTIVE, 2'h0, 1'b0);
        send(`SBCL_CMD_ACTIVE, 2'h1, 1'b0);
        wait_st(1, `SBCL_ST_ACTIVE, "bank1");
        send(`SBCL_CMD_READ, 2'h0, 1'b0);
        send(`SBCL_CMD_WRITE, 2'h1, 1'b0);
        repeat (3) @(posedge sys_clk);
        #2;
        check("bank0", `SBCL_ST_ACTIVE, bank_state[7:0]);
        check("bank1", `SBCL_ST_WRITE, bank_state[15:8]);
        send(`SBCL_CMD_PRE, 2'h2, 1'b1);
        wait_st(0, `SBCL_ST_IDLE, "bank0");
        wait_st(1, `SBCL_ST_IDLE, "bank1");
        repeat (3) @(posedge sys_clk);
        #2;
        check("all_idle", 1'b1, all_idle);
        send(`SBCL_CMD_REF, 2'h0, 1'b0);
        repeat (3) @(posedge sys_clk);
        #2;
        check("all_idle", 1'b0, all_idle);
        repeat (`SBCL_REFRESH_CYC + 1) @(posedge sys_clk);
        send(`SBCL_CMD_MRS, 2'h0, 1'b0);
        repeat (`SBCL_MODE_LOAD_CYC + 4) @(posedge sys_clk);
        #2;
        check("all_idle", 1'b1, all_idle);
        send(`SBCL_CMD_PRE, 2'h3, 1'b0);
        send(`SBCL_CMD_ACTIVE, 2'h1, 1'b0);
        wait_st(1, `SBCL_ST_ACTIVE, "bank1");
        check("bank3", `SBCL_ST_IDLE, bank_state[31:24]);
        send(`SBCL_CMD_PRE, 2'h1, 1'b0);
        wait_st(1, `SBCL_ST_IDLE, "bank1");
        $display("done global");
    endtask
    task automatic t_gate();
        @(posedge sys_clk);
        #1;
        cke = 1'b0;
        send(`SBCL_CMD_ACTIVE, 2'h3, 1'b0);
        repeat (8) @(posedge sys_clk);
        #1;
        cke = 1'b1;
        sr_exit = 1'b1;
        check("bank3", `SBCL_ST_IDLE, bank_state[31:24]);
        send(`SBCL_CMD_ACTIVE, 2'h3, 1'b0);
        repeat (6) @(posedge sys_clk);
        #2;
        check("bank3", `SBCL_ST_IDLE, bank_state[31:24]);
        repeat (12) @(posedge sys_clk);
        send(`SBCL_CMD_ACTIVE, 2'h3, 1'b0);
        wait_st(3, `SBCL_ST_ACTIVE, "bank3");
        send(`SBCL_CMD_PRE, 2'h3, 1'b0);
        wait_st(3, `SBCL_ST_IDLE, "bank3");
        $display("done gate");
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        t_decode();
        t_read();
        t_write();
        t_global();
        t_gate();
        results();
    end
endmodule // test_sdram_bank_command_legality
`default_nettype wire
